// File: osdec_top.sv
// Command decoder of a 128x64 display driver behind an Avalon-MM slave with waitrequest.
// Assumes a master that holds each request until it sees waitrequest low.
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module osdec_top #(
  parameter int FRAME_CYCLES = osdec_pkg::FRAME_CYCLES_DFLT,
  parameter int MULTIPLEX_RATIO = osdec_pkg::MULTIPLEX_RATIO_DFLT
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [osdec_pkg::ADDR_W-1:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest // Stall, high until the request is served.
);
  typedef struct packed {
    osdec_pkg::osdec_state_e state;
    logic [7:0] op;
    logic [3:0] cnt;
    logic [6:0][7:0] prm;
    logic waitreq;
    logic [31:0] rdata;
    logic serial;
    logic com_alt;
    logic com_swap;
    logic [7:0] desel;
    logic disp_on;
    logic pump_en;
    logic [7:0] pump_mode;
    logic sc_active;
    logic sc_left;
    logic h_en;
    logic v_en;
    logic [2:0] sp;
    logic [2:0] ep;
    logic [2:0] speed;
    logic [5:0] voff;
    logic [6:0] scol;
    logic [6:0] ecol;
    logic setup_ok;
    logic restart;
    logic [5:0] vtop;
    logic [6:0] vrows;
    logic [2:0] csp;
    logic [2:0] cep;
    logic [6:0] csc;
    logic [6:0] cec;
    logic cleft;
    logic [6:0] ccount;
    logic [1:0] amode;
    logic [6:0] wcs;
    logic [6:0] wce;
    logic [2:0] wps;
    logic [2:0] wpe;
    logic [1:0] fade;
    logic [3:0] fint;
    logic zoom;
    logic area_err;
    logic setup_err;
  } osdec_top_s;
  osdec_top_s r, n;
  logic [6:0] col_ofs;
  logic [5:0] row_ofs;
  logic req;
  logic acc;
  logic byte_in;
  logic ctrl_wr;
  logic [3:0] np;
  logic [7:0] status;
  logic [31:0] rword;
  logic [7:0] b;

  osdec_scroll_step #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_step (
    .clk(clk),
    .resetn(resetn),
    .active(r.sc_active),
    .restart(r.restart),
    .h_en(r.h_en),
    .v_en(r.v_en),
    .left(r.sc_left),
    .speed(r.speed),
    .voff(r.voff),
    .vrows(r.vrows),
    .col_ofs(col_ofs),
    .row_ofs(row_ofs)
  );

  always_comb begin
    n = r;
    n.restart = 1'b0;
    req = avs_read | avs_write;
    acc = req & ~r.waitreq;
    b = avs_writedata[7:0];
    byte_in = acc & avs_write & (avs_address == osdec_pkg::OFS_CMD) & avs_byteenable[0];
    ctrl_wr = acc & avs_write & (avs_address == osdec_pkg::OFS_CTRL) & avs_byteenable[0];
    np = osdec_pkg::osdec_nparams(r.op);
    status = 8'h00;
    status[osdec_pkg::ST_ACTIVE] = r.sc_active;
    status[osdec_pkg::ST_BUSY] = (r.state != osdec_pkg::OSDEC_IDLE);
    status[osdec_pkg::ST_AREA_ERR] = r.area_err;
    status[osdec_pkg::ST_SETUP_ERR] = r.setup_err;
    status[osdec_pkg::ST_DISP_OFF] = ~r.disp_on;
    case (avs_address)
      osdec_pkg::OFS_CMD: rword = r.serial ? 32'h0 : {24'h0, status};
      osdec_pkg::OFS_CTRL: rword = {31'h0, r.serial};
      osdec_pkg::OFS_PANEL: rword = {r.pump_mode, 6'h0, r.pump_en, r.disp_on, r.desel, 6'h0, r.com_swap, r.com_alt};
      osdec_pkg::OFS_SCROLL: rword = {10'h0, r.voff, 1'b0, r.speed, 1'b0, r.ep, r.sp,
                                      r.setup_ok, r.v_en, r.h_en, r.sc_left, r.sc_active};
      osdec_pkg::OFS_SCRWIN: rword = {1'b0, r.vrows, 2'h0, r.vtop, 1'b0, r.ecol, 1'b0, r.scol};
      osdec_pkg::OFS_POS: rword = {7'h0, r.cleft, 1'b0, r.ccount, 2'h0, row_ofs, 1'b0, col_ofs};
      osdec_pkg::OFS_ADDRWIN: rword = {1'b0, r.wpe, 1'b0, r.wps, 1'b0, r.wce, 1'b0, r.wcs, 6'h0, r.amode};
      osdec_pkg::OFS_GFX: rword = {20'h0, r.setup_err, r.area_err, r.zoom & r.com_alt, r.zoom, r.fint, 2'h0, r.fade};
      osdec_pkg::OFS_CWIN: rword = {9'h0, r.cec, 1'b0, r.csc, 1'b0, r.cep, 1'b0, r.csp};
      default: rword = 32'h0;
    endcase
    // One stall cycle per request; read data are captured in that cycle.
    n.waitreq = ~(req & r.waitreq);
    if (avs_read & r.waitreq) begin
      n.rdata = rword;
    end
    if (ctrl_wr) begin
      n.serial = avs_writedata[osdec_pkg::CTRL_SERIAL];
      if (avs_writedata[osdec_pkg::CTRL_CLR_ERR]) begin
        n.area_err = 1'b0;
        n.setup_err = 1'b0;
      end
    end
    case (r.state)
      osdec_pkg::OSDEC_IDLE: begin
        if (byte_in) begin
          n.op = b;
          n.cnt = 4'h0;
          if (osdec_pkg::osdec_nparams(b) == 4'h0) begin
            n.state = osdec_pkg::OSDEC_EXEC;
          end else if (osdec_pkg::osdec_nparams(b) != osdec_pkg::NP_UNKNOWN) begin
            n.state = osdec_pkg::OSDEC_PARAM;
          end
        end
      end
      osdec_pkg::OSDEC_PARAM: begin
        if (byte_in) begin
          n.prm[r.cnt[2:0]] = b;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == np - 4'h1) begin
            n.state = osdec_pkg::OSDEC_EXEC;
          end
        end
      end
      osdec_pkg::OSDEC_EXEC: begin
        n.state = osdec_pkg::OSDEC_IDLE;
        case (r.op)
          osdec_pkg::OP_COM_CFG: begin
            n.com_alt = r.prm[0][osdec_pkg::COM_ALT_BIT];
            n.com_swap = r.prm[0][osdec_pkg::COM_SWAP_BIT];
          end
          osdec_pkg::OP_DESEL: n.desel = r.prm[0];
          osdec_pkg::OP_PUMP: begin
            n.pump_en = r.prm[0][osdec_pkg::PUMP_EN_BIT];
            n.pump_mode = r.prm[0];
          end
          osdec_pkg::OP_DISP_ON: n.disp_on = 1'b1;
          osdec_pkg::OP_DISP_OFF: n.disp_on = 1'b0;
          osdec_pkg::OP_HSCR_R, osdec_pkg::OP_HSCR_L: begin
            n.sc_left = (r.op == osdec_pkg::OP_HSCR_L);
            n.sp = r.prm[1][2:0];
            n.speed = r.prm[2][2:0];
            n.ep = r.prm[3][2:0];
            n.h_en = 1'b1;
            n.v_en = 1'b0;
            n.voff = 6'h0;
            n.scol = 7'h0;
            n.ecol = osdec_pkg::COL_LAST;
            n.setup_ok = 1'b1;
            n.restart = 1'b1;
            n.setup_err = n.setup_err | r.sc_active;
          end
          osdec_pkg::OP_VHSCR_R, osdec_pkg::OP_VHSCR_L: begin
            n.sc_left = (r.op == osdec_pkg::OP_VHSCR_L);
            n.h_en = r.prm[0][0];
            n.sp = r.prm[1][2:0];
            n.speed = r.prm[2][2:0];
            n.ep = r.prm[3][2:0];
            n.voff = r.prm[4][5:0];
            n.v_en = |r.prm[4][3:0];
            n.scol = r.prm[5][6:0];
            n.ecol = r.prm[6][6:0];
            n.setup_ok = 1'b1;
            n.restart = 1'b1;
            n.setup_err = n.setup_err | r.sc_active;
          end
          osdec_pkg::OP_SCR_OFF: n.sc_active = 1'b0;
          osdec_pkg::OP_SCR_ON: n.sc_active = r.setup_ok;
          osdec_pkg::OP_VAREA: begin
            if (8'(r.prm[0][5:0]) + 8'(r.prm[1][6:0]) <= 8'(MULTIPLEX_RATIO)) begin
              n.vtop = r.prm[0][5:0];
              n.vrows = r.prm[1][6:0];
            end else begin
              n.area_err = 1'b1;
            end
          end
          osdec_pkg::OP_CSCR_R, osdec_pkg::OP_CSCR_L: begin
            n.csp = r.prm[1][2:0];
            n.cep = r.prm[3][2:0];
            n.csc = r.prm[4][6:0];
            n.cec = r.prm[5][6:0];
            n.cleft = (r.op == osdec_pkg::OP_CSCR_L);
            n.ccount = (r.op == osdec_pkg::OP_CSCR_L) ? r.ccount + 7'h1 : r.ccount - 7'h1;
          end
          osdec_pkg::OP_ADDR_MODE: n.amode = r.prm[0][1:0];
          osdec_pkg::OP_COL_WIN: begin
            n.wcs = r.prm[0][6:0];
            n.wce = r.prm[1][6:0];
          end
          osdec_pkg::OP_PAGE_WIN: begin
            n.wps = r.prm[0][2:0];
            n.wpe = r.prm[1][2:0];
          end
          osdec_pkg::OP_FADE: begin
            n.fade = r.prm[0][5:4];
            n.fint = r.prm[0][3:0];
          end
          osdec_pkg::OP_ZOOM: n.zoom = r.prm[0][0];
          default: n.state = osdec_pkg::OSDEC_IDLE;
        endcase
      end
      default: n.state = osdec_pkg::OSDEC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.state <= osdec_pkg::OSDEC_IDLE;
      r.waitreq <= 1'b1;
      r.desel <= osdec_pkg::DESEL_RST;
      r.amode <= osdec_pkg::AMODE_RST;
      r.ecol <= osdec_pkg::COL_LAST;
      r.wce <= osdec_pkg::COL_LAST;
      r.wpe <= osdec_pkg::PAGE_LAST;
      r.vrows <= osdec_pkg::VROWS_RST;
      r.com_alt <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic exec;
  assign exec = (r.state == osdec_pkg::OSDEC_EXEC);
  sequence s_last_param;
    r.state == osdec_pkg::OSDEC_PARAM && byte_in && r.cnt == np - 4'h1;
  endsequence
  sequence s_back_to_decode;
    r.state == osdec_pkg::OSDEC_EXEC ##1 r.state == osdec_pkg::OSDEC_IDLE;
  endsequence
  a_param_return: assert property (s_last_param |=> s_back_to_decode)
    else $error("decoder did not return to opcode decoding");
  a_com_layout: assert property (exec && r.op == osdec_pkg::OP_COM_CFG |=>
      r.com_alt == $past(r.prm[0][4]) && r.com_swap == $past(r.prm[0][5]))
    else $error("COM layout bits not taken from parameter");
  a_desel_load: assert property (exec && r.op == osdec_pkg::OP_DESEL |=> r.desel == $past(r.prm[0]))
    else $error("deselect level not loaded");
  a_status_read: assert property (avs_read && r.waitreq && avs_address == osdec_pkg::OFS_CMD && !r.serial
      |=> avs_readdata[7:0] == $past(status) && !avs_waitrequest)
    else $error("status byte not returned");
  a_serial_silent: assert property (avs_read && r.waitreq && avs_address == osdec_pkg::OFS_CMD && r.serial
      |=> avs_readdata == 32'h0)
    else $error("status returned while serial host selected");
  a_honly_mode: assert property (exec && (r.op == osdec_pkg::OP_VHSCR_R || r.op == osdec_pkg::OP_VHSCR_L)
      && r.prm[4][3:0] == 4'h0 |=> !r.v_en)
    else $error("vertical motion with zero vertical offset");
  a_vonly_mode: assert property (exec && (r.op == osdec_pkg::OP_VHSCR_R || r.op == osdec_pkg::OP_VHSCR_L)
      && !r.prm[0][0] |=> !r.h_en)
    else $error("horizontal motion with zero column offset");
  a_scroll_start: assert property (exec && r.op == osdec_pkg::OP_SCR_ON && r.setup_ok |=> r.sc_active)
    else $error("activate did not start scrolling");
  a_scroll_stop: assert property (exec && r.op == osdec_pkg::OP_SCR_OFF |=> !r.sc_active [*2])
    else $error("deactivate did not stop scrolling");
  a_area_limit: assert property (8'(r.vtop) + 8'(r.vrows) <= 8'(MULTIPLEX_RATIO))
    else $error("vertical area exceeds multiplex ratio");
  a_content_step: assert property (exec && r.op == osdec_pkg::OP_CSCR_L |=> r.ccount == $past(r.ccount) + 7'h1)
    else $error("content scroll did not move one column");
  a_addr_mode: assert property (exec && r.op == osdec_pkg::OP_ADDR_MODE |=> r.amode == $past(r.prm[0][1:0]))
    else $error("addressing mode not taken");

  // Bus handshake: exactly one stall cycle, then one served cycle.
  sequence s_req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_wait_drop: assert property (s_req_seen |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one stall cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_unknown_idle: assert property (r.state == osdec_pkg::OSDEC_IDLE && byte_in
      && osdec_pkg::osdec_nparams(b) == osdec_pkg::NP_UNKNOWN |=> r.state == osdec_pkg::OSDEC_IDLE)
    else $error("unknown opcode left the decoder busy");
  a_hscroll_full: assert property (exec && (r.op == osdec_pkg::OP_HSCR_R || r.op == osdec_pkg::OP_HSCR_L)
      |=> r.scol == 7'h00 && r.ecol == osdec_pkg::COL_LAST && r.h_en && !r.v_en)
    else $error("horizontal scroll setup did not cover all columns");
  a_diag_mode: assert property (exec && (r.op == osdec_pkg::OP_VHSCR_R || r.op == osdec_pkg::OP_VHSCR_L)
      && r.prm[0][0] && r.prm[4][3:0] != 4'h0 |=> r.h_en && r.v_en)
    else $error("diagonal scroll not enabled with both offsets set");
  sequence s_setup_exec;
    exec && (r.op == osdec_pkg::OP_HSCR_R || r.op == osdec_pkg::OP_HSCR_L
      || r.op == osdec_pkg::OP_VHSCR_R || r.op == osdec_pkg::OP_VHSCR_L);
  endsequence
  sequence s_restart_pulse;
    r.restart && r.setup_ok ##1 !r.restart;
  endsequence
  a_setup_latest: assert property (s_setup_exec |=> s_restart_pulse)
    else $error("scroll setup did not replace the earlier one");
  a_hscroll_len: assert property (exec && (r.op == osdec_pkg::OP_HSCR_R || r.op == osdec_pkg::OP_HSCR_L)
      |-> r.cnt == 4'h6)
    else $error("horizontal scroll setup not seven bytes long");
  a_vhscroll_len: assert property (exec && (r.op == osdec_pkg::OP_VHSCR_R || r.op == osdec_pkg::OP_VHSCR_L)
      |-> r.cnt == 4'h7)
    else $error("combined scroll setup not eight bytes long");
  a_varea_len: assert property (exec && r.op == osdec_pkg::OP_VAREA |-> r.cnt == 4'h2)
    else $error("vertical area command not three bytes long");
  a_area_reject: assert property (exec && r.op == osdec_pkg::OP_VAREA
      && 8'(r.prm[0][5:0]) + 8'(r.prm[1][6:0]) > 8'(MULTIPLEX_RATIO) |=> r.area_err && $stable(r.vrows))
    else $error("oversized vertical area was not refused");
  a_content_right: assert property (exec && r.op == osdec_pkg::OP_CSCR_R
      |=> r.ccount == $past(r.ccount) - 7'h1)
    else $error("content scroll right did not move one column");
  a_col_window: assert property (exec && r.op == osdec_pkg::OP_COL_WIN
      |=> r.wcs == $past(r.prm[0][6:0]) && r.wce == $past(r.prm[1][6:0]))
    else $error("column window not loaded");
  a_page_window: assert property (exec && r.op == osdec_pkg::OP_PAGE_WIN
      |=> r.wps == $past(r.prm[0][2:0]) && r.wpe == $past(r.prm[1][2:0]))
    else $error("page window not loaded");
  a_fade_load: assert property (exec && r.op == osdec_pkg::OP_FADE
      |=> r.fade == $past(r.prm[0][5:4]) && r.fint == $past(r.prm[0][3:0]))
    else $error("fade setting not loaded");
  a_zoom_load: assert property (exec && r.op == osdec_pkg::OP_ZOOM |=> r.zoom == $past(r.prm[0][0]))
    else $error("zoom setting not taken");
  a_disp_on: assert property (exec && r.op == osdec_pkg::OP_DISP_ON |=> r.disp_on)
    else $error("display-on command not taken");
endmodule // osdec_top

// File: osdec_pkg.sv
// Constants, opcodes, register map and decode helpers of the display command decoder.
// Assumes a 100 MHz system clock and one command byte per register-bus write.
package osdec_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_PERIOD_NS = 10_000_000;
  localparam int FRAME_CYCLES_DFLT = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MULTIPLEX_RATIO_DFLT = 64;
  localparam int ADDR_W = 6;

  localparam logic [5:0] OFS_CMD = 6'h00;
  localparam logic [5:0] OFS_CTRL = 6'h04;
  localparam logic [5:0] OFS_PANEL = 6'h08;
  localparam logic [5:0] OFS_SCROLL = 6'h0C;
  localparam logic [5:0] OFS_SCRWIN = 6'h10;
  localparam logic [5:0] OFS_POS = 6'h14;
  localparam logic [5:0] OFS_ADDRWIN = 6'h18;
  localparam logic [5:0] OFS_GFX = 6'h1C;
  localparam logic [5:0] OFS_CWIN = 6'h20;

  localparam int ST_ACTIVE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_AREA_ERR = 2;
  localparam int ST_SETUP_ERR = 3;
  localparam int ST_DISP_OFF = 6;
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_CLR_ERR = 1;
  localparam int COM_ALT_BIT = 4;
  localparam int COM_SWAP_BIT = 5;
  localparam int PUMP_EN_BIT = 2;

  localparam logic [7:0] OP_HSCR_R = 8'h26;
  localparam logic [7:0] OP_HSCR_L = 8'h27;
  localparam logic [7:0] OP_VHSCR_R = 8'h29;
  localparam logic [7:0] OP_VHSCR_L = 8'h2A;
  localparam logic [7:0] OP_CSCR_R = 8'h2C;
  localparam logic [7:0] OP_CSCR_L = 8'h2D;
  localparam logic [7:0] OP_SCR_OFF = 8'h2E;
  localparam logic [7:0] OP_SCR_ON = 8'h2F;
  localparam logic [7:0] OP_ADDR_MODE = 8'h20;
  localparam logic [7:0] OP_COL_WIN = 8'h21;
  localparam logic [7:0] OP_PAGE_WIN = 8'h22;
  localparam logic [7:0] OP_FADE = 8'h23;
  localparam logic [7:0] OP_VAREA = 8'hA3;
  localparam logic [7:0] OP_PUMP = 8'h8D;
  localparam logic [7:0] OP_DISP_OFF = 8'hAE;
  localparam logic [7:0] OP_DISP_ON = 8'hAF;
  localparam logic [7:0] OP_ZOOM = 8'hD6;
  localparam logic [7:0] OP_COM_CFG = 8'hDA;
  localparam logic [7:0] OP_DESEL = 8'hDB;
  localparam logic [7:0] OP_NOP = 8'hE3;

  localparam logic [3:0] NP_UNKNOWN = 4'h8;
  localparam logic [6:0] COL_LAST = 7'h7F;
  localparam logic [1:0] AMODE_RST = 2'h2;
  localparam logic [7:0] DESEL_RST = 8'h20;
  localparam logic [2:0] PAGE_LAST = 3'h7;
  localparam logic [6:0] VROWS_RST = 7'h40;

  typedef enum logic [2:0] {
    OSDEC_IDLE = 3'b001,
    OSDEC_PARAM = 3'b010,
    OSDEC_EXEC = 3'b100
  } osdec_state_e;

  // Number of parameter bytes after each opcode.
  function automatic logic [3:0] osdec_nparams(input logic [7:0] op);
    case (op)
      OP_HSCR_R, OP_HSCR_L, OP_CSCR_R, OP_CSCR_L: osdec_nparams = 4'h6;
      OP_VHSCR_R, OP_VHSCR_L: osdec_nparams = 4'h7;
      OP_VAREA, OP_COL_WIN, OP_PAGE_WIN: osdec_nparams = 4'h2;
      OP_COM_CFG, OP_DESEL, OP_PUMP, OP_ADDR_MODE, OP_FADE, OP_ZOOM: osdec_nparams = 4'h1;
      OP_SCR_OFF, OP_SCR_ON, OP_DISP_OFF, OP_DISP_ON, OP_NOP: osdec_nparams = 4'h0;
      default: osdec_nparams = NP_UNKNOWN;
    endcase
  endfunction
endpackage

// File: osdec_scroll_step.sv
// Continuous scroll offset generator paced by frame periods.
// Assumes the decoder holds its scroll setup steady while scrolling runs.
`timescale 1ns/10ps
module osdec_scroll_step #(
  parameter int FRAME_CYCLES = osdec_pkg::FRAME_CYCLES_DFLT
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic active, // Scrolling enabled.
  input wire logic restart, // New setup: offsets back to zero.
  input wire logic h_en, // Horizontal motion on.
  input wire logic v_en, // Vertical motion on.
  input wire logic left, // Horizontal direction is left.
  input wire logic [2:0] speed, // Step interval is 2**speed frames.
  input wire logic [5:0] voff, // Rows moved per step.
  input wire logic [6:0] vrows, // Rows in the vertical area.
  output logic [6:0] col_ofs, // Column rotation offset.
  output logic [5:0] row_ofs // Vertical offset within the area.
);
  typedef struct packed {
    logic [31:0] fcnt;
    logic [7:0] frames;
    logic [6:0] col;
    logic [5:0] row;
  } osdec_step_s;
  osdec_step_s r, n;
  logic frame_end;
  logic step;
  logic [6:0] row_sum;
  always_comb begin
    n = r;
    frame_end = (r.fcnt == 32'(FRAME_CYCLES - 1));
    step = active & frame_end & (r.frames == 8'((1 << speed) - 1));
    row_sum = 7'(r.row) + 7'(voff);
    if (restart) begin
      n = '0;
    end else if (active) begin
      n.fcnt = frame_end ? 32'h0 : r.fcnt + 32'h1;
      if (frame_end) begin
        n.frames = step ? 8'h0 : r.frames + 8'h1;
      end
      if (step && h_en) begin
        n.col = left ? r.col + 7'h1 : r.col - 7'h1;
      end
      if (step && v_en) begin
        n.row = (vrows == 7'h0) ? 6'h0 : ((row_sum >= vrows) ? 6'(row_sum - vrows) : 6'(row_sum));
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign col_ofs = r.col;
  assign row_ofs = r.row;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_col_wrap: assert property (step && h_en && !left && !restart && r.col == 7'h0 |=> r.col == 7'h7F)
    else $error("column offset did not wrap to the far edge");
  a_col_hold: assert property (!active && !restart |=> $stable(r.col))
    else $error("column offset moved while scrolling was off");
endmodule // osdec_scroll_step

// File: osdec_host.sv
// Host model: an Avalon-MM master that sends command bytes and reads registers.
// Assumes a slave that drops waitrequest for one cycle for each request it serves.
`timescale 1ns/10ps
module osdec_host #(
  parameter int FRAME_CYCLES = 16
) (
  input wire logic clk, // System clock.
  output logic [osdec_pkg::ADDR_W-1:0] avs_address, // Byte address.
  output logic avs_read, // Read request.
  output logic avs_write, // Write request.
  output logic [31:0] avs_writedata, // Write data.
  output logic [3:0] avs_byteenable, // Byte lanes.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic avs_waitrequest // Slave stall.
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
  end

  // The request stands until waitrequest is sampled low; released data is inverted so it is never reused.
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask

  task automatic bus_read(input logic [5:0] a, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] b);
    bus_write(osdec_pkg::OFS_CMD, {24'h000000, b}, 4'h1);
  endtask

  // Pump command, then the mode byte, then display on, in that order.
  task automatic pump_on(input logic [7:0] mode);
    cmd(osdec_pkg::OP_PUMP);
    cmd(mode);
    cmd(osdec_pkg::OP_DISP_ON);
  endtask

  // Spacing of two frames between consecutive content scroll commands.
  task automatic frame_gap;
    repeat (2 * FRAME_CYCLES) @(posedge clk);
  endtask
endmodule // osdec_host

// File: test_osdec_top.sv
// Self-checking testbench of the display command decoder.
// Assumes the register layout of the decoder's hand-over and a shortened frame period.
`timescale 1ns/10ps
module test_osdec_top;
  localparam int FC = 16;
  logic clk;
  logic resetn;
  logic [osdec_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_errors = 0;
  int n_compared = 0;

  osdec_top #(.FRAME_CYCLES(FC), .MULTIPLEX_RATIO(64)) osdec_top_i (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  osdec_host #(.FRAME_CYCLES(FC)) osdec_host_i (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] q;
    osdec_host_i.bus_read(a, q);
    n_compared++;
    if ((q & m) !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, q & m);
    end
  endtask

  // Sends a whole command; the decoder must be busy just before a final parameter byte and idle after the last byte.
  task automatic send(input logic [7:0] b[]);
    foreach (b[i]) begin
      if (i == b.size() - 1 && i > 0) check(osdec_pkg::OFS_CMD, 32'h2, 32'h2, "busy before last byte");
      osdec_host_i.cmd(b[i]);
    end
    check(osdec_pkg::OFS_CMD, 32'h2, 32'h0, "busy after last byte");
  endtask

  task automatic wait_move;
    logic [31:0] q;
    q = '0;
    for (int k = 0; k < 100 && q[6:0] == 7'h00; k++) osdec_host_i.bus_read(osdec_pkg::OFS_POS, q);
  endtask

  initial begin
    #300000;
    n_errors++;
    print_verdict;
  end

  initial begin
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    check(osdec_pkg::OFS_PANEL, '1, 32'h0000_2001, "panel reset");
    check(osdec_pkg::OFS_ADDRWIN, '1, 32'h707F_0002, "address window reset");
    check(osdec_pkg::OFS_SCRWIN, '1, 32'h4000_7F00, "scroll window reset");
    check(osdec_pkg::OFS_CMD, '1, 32'h0000_0040, "status reset");
    osdec_host_i.bus_write(6'h3C, 32'hFFFF_FFFF, 4'hF);
    check(6'h3C, '1, 32'h0000_0000, "unmapped read");
    osdec_host_i.bus_write(osdec_pkg::OFS_CMD, 32'h0000_008D, 4'hE);
    osdec_host_i.bus_write(osdec_pkg::OFS_CTRL, 32'h0000_0001, 4'hF);
    check(osdec_pkg::OFS_CMD, '1, 32'h0000_0000, "status in serial mode");
    osdec_host_i.bus_write(osdec_pkg::OFS_CTRL, 32'h0000_0000, 4'hF);
    check(osdec_pkg::OFS_CMD, '1, 32'h0000_0040, "status in parallel mode");
    send('{8'hDA, 8'h20});
    send('{8'hDB, 8'h30});
    check(osdec_pkg::OFS_PANEL, '1, 32'h0000_3002, "layout and deselect");
    osdec_host_i.pump_on(8'h14);
    check(osdec_pkg::OFS_PANEL, '1, 32'h1403_3002, "pump and display on");
    check(osdec_pkg::OFS_CMD, '1, 32'h0000_0000, "status display on");
    send('{8'h26, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'hFF});
    check(osdec_pkg::OFS_SCROLL, '1, 32'h0000_0334, "right scroll setup");
    osdec_host_i.cmd(osdec_pkg::OP_SCR_ON);
    check(osdec_pkg::OFS_CMD, 32'h1, 32'h1, "scroll active");
    wait_move;
    check(osdec_pkg::OFS_POS, 32'h7F, 32'h7F, "right step wraps");
    osdec_host_i.cmd(osdec_pkg::OP_SCR_OFF);
    check(osdec_pkg::OFS_CMD, 32'h1, 32'h0, "scroll stopped");
    send('{8'h27, 8'h00, 8'h02, 8'h00, 8'h05, 8'h00, 8'hFF});
    repeat (4 * FC) @(posedge clk);
    check(osdec_pkg::OFS_POS, 32'h7F, 32'h00, "no motion while stopped");
    check(osdec_pkg::OFS_SCROLL, '1, 32'h0000_0556, "left scroll setup");
    osdec_host_i.cmd(osdec_pkg::OP_SCR_ON);
    wait_move;
    check(osdec_pkg::OFS_POS, 32'h7F, 32'h01, "left step from latest setup");
    osdec_host_i.cmd(osdec_pkg::OP_SCR_OFF);
    send('{8'h29, 8'h00, 8'h00, 8'h00, 8'h07, 8'h01, 8'h00, 8'h7F});
    check(osdec_pkg::OFS_SCROLL, '1, 32'h0001_0718, "vertical only");
    send('{8'h2A, 8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h7F});
    check(osdec_pkg::OFS_SCROLL, '1, 32'h0000_0716, "horizontal only");
    send('{8'h29, 8'h01, 8'h00, 8'h00, 8'h07, 8'h02, 8'h03, 8'h40});
    check(osdec_pkg::OFS_SCROLL, '1, 32'h0002_071C, "diagonal");
    check(osdec_pkg::OFS_SCRWIN, '1, 32'h4000_4003, "diagonal columns");
    send('{8'hA3, 8'h08, 8'h38});
    check(osdec_pkg::OFS_SCRWIN, '1, 32'h3808_4003, "area at limit");
    send('{8'hA3, 8'h09, 8'h38});
    check(osdec_pkg::OFS_SCRWIN, '1, 32'h3808_4003, "area over limit kept");
    check(osdec_pkg::OFS_CMD, 32'h4, 32'h4, "area error flag");
    send('{8'h2D, 8'h00, 8'h02, 8'h01, 8'h05, 8'h08, 8'h78});
    check(osdec_pkg::OFS_CWIN, '1, 32'h0078_0852, "content window");
    check(osdec_pkg::OFS_POS, 32'h01FF_0000, 32'h0101_0000, "content left one");
    osdec_host_i.frame_gap;
    send('{8'h2C, 8'h00, 8'h02, 8'h01, 8'h05, 8'h08, 8'h78});
    check(osdec_pkg::OFS_POS, 32'h01FF_0000, 32'h0000_0000, "content right one");
    osdec_host_i.frame_gap;
    send('{8'h2C, 8'h00, 8'h02, 8'h01, 8'h05, 8'h08, 8'h78});
    check(osdec_pkg::OFS_POS, 32'h01FF_0000, 32'h007F_0000, "content right wraps");
    for (int m = 0; m < 3; m++) begin
      send('{8'h20, 8'(m)});
      check(osdec_pkg::OFS_ADDRWIN, 32'h3, 32'(m), "addressing mode");
    end
    send('{8'h20, 8'h01});
    send('{8'h21, 8'h78, 8'h78});
    send('{8'h22, 8'h02, 8'h05});
    check(osdec_pkg::OFS_ADDRWIN, '1, 32'h5278_7801, "write window");
    send('{8'h23, 8'h2A});
    send('{8'hD6, 8'h01});
    check(osdec_pkg::OFS_GFX, 32'h3FF, 32'h1A2, "zoom without alternative layout");
    send('{8'hDA, 8'h10});
    check(osdec_pkg::OFS_GFX, 32'h3FF, 32'h3A2, "zoom with alternative layout");
    osdec_host_i.bus_write(osdec_pkg::OFS_CTRL, 32'h0000_0002, 4'h1);
    osdec_host_i.cmd(osdec_pkg::OP_DISP_OFF);
    osdec_host_i.cmd(8'hFF);
    osdec_host_i.cmd(osdec_pkg::OP_NOP);
    check(osdec_pkg::OFS_CMD, '1, 32'h0000_0040, "errors cleared, display off, idle");
    print_verdict;
  end
endmodule // test_osdec_top
